// file: src/bit_sync_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none

interface bit_sync_cfg_if;
    logic [1:0] presync_integral_gain;
    logic [1:0] presync_proportional_gain;
    logic       postsync_integral_gain;
    logic       postsync_proportional_gain;
    logic [1:0] rate_offset_limit;
    logic       sync_found;
    logic [3:0] ki_half;
    logic [2:0] kp;
    logic [2:0] limit_steps;

    modport source (
        output presync_integral_gain,
        output presync_proportional_gain,
        output postsync_integral_gain,
        output postsync_proportional_gain,
        output rate_offset_limit,
        output sync_found,
        input  ki_half,
        input  kp,
        input  limit_steps
    );

    modport decode (
        input  presync_integral_gain,
        input  presync_proportional_gain,
        input  postsync_integral_gain,
        input  postsync_proportional_gain,
        input  rate_offset_limit,
        input  sync_found,
        output ki_half,
        output kp,
        output limit_steps
    );
endinterface : bit_sync_cfg_if

`default_nettype wire

// file: src/bit_sync_gain_decode.sv
`timescale 1ns/1ns
`default_nettype none

module bit_sync_gain_decode
    import bit_sync_pkg::*;
(
    bit_sync_cfg_if.decode cfg
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [2:0] times_code(input logic [1:0] code);
        times_code = {1'b0, code} + 3'h1;
    endfunction : times_code

    function automatic logic [2:0] limit_of(input logic [1:0] code);
        unique case (code)
            LIMIT_OFF:   limit_of = STEPS_NONE;
            LIMIT_3P125: limit_of = STEPS_3P125;
            LIMIT_6P25:  limit_of = STEPS_6P25;
            LIMIT_12P5:  limit_of = STEPS_12P5;
        endcase
    endfunction : limit_of

    wire logic [2:0] pre_ki_mult;
    wire logic [2:0] pre_kp_mult;
    wire logic       use_half_ki;
    wire logic       use_base_kp;

    assign pre_ki_mult = times_code(cfg.presync_integral_gain);
    assign pre_kp_mult = times_code(cfg.presync_proportional_gain);
    assign use_half_ki = cfg.sync_found & cfg.postsync_integral_gain;
    assign use_base_kp = cfg.sync_found & cfg.postsync_proportional_gain;

    // Integral kept in halves so K/2 stays an integer
    assign cfg.ki_half     = use_half_ki ? KI_HALF_BASE : {pre_ki_mult, 1'b0};
    assign cfg.kp          = use_base_kp ? KP_BASE : pre_kp_mult;
    assign cfg.limit_steps = limit_of(cfg.rate_offset_limit);

endmodule : bit_sync_gain_decode

`default_nettype wire

// file: src/bit_sync_loop_config.sv
//Behaviour
// - Bits 7:6 pick presync integral gain one to four times base; reset 01.
// - Bits 5:4 pick presync proportional gain one to four times base; reset 10.
// - After sync, bit 3 set gives half base integral gain, else presync.
// - After sync, bit 2 set gives base proportional gain, else presync.
// - Bits 1:0 limit rate compensation: off, 3.125, 6.25, 12.5 percent.
// - Integral path tracks and corrects symbol rate mismatch only when bits 1:0 are not off.
// - Freeze gating bit holds loops frozen until carrier sense asserts.
`timescale 1ns/1ns
`default_nettype none

module bit_sync_loop_config
    import bit_sync_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    input  wire logic [5:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       sync_found_i,
    input  wire logic       carrier_sense_i,
    input  wire logic       loop_freeze_until_carrier_i,
    output logic      [7:0] reg_rdata_o,
    output logic      [3:0] integral_gain_half_o,
    output logic      [2:0] proportional_gain_o,
    output logic      [2:0] rate_limit_steps_o,
    output logic            integral_track_en_o,
    output logic            loops_frozen_o
);

    // ****************************************
    // Register
    // ****************************************
    logic [7:0] bit_sync_config;

    wire logic addr_hit;
    wire logic write_hit;
    wire logic read_hit;

    assign addr_hit  = (reg_addr_i == BIT_SYNC_CONFIG_ADDR);
    assign write_hit = reg_write_i & addr_hit;
    assign read_hit  = reg_read_i & addr_hit;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            bit_sync_config <= BIT_SYNC_CONFIG_RESET;
        end else if (write_hit) begin
            bit_sync_config <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= READ_IDLE_DATA;
        end else if (read_hit) begin
            reg_rdata_o <= bit_sync_config;
        end else begin
            reg_rdata_o <= READ_IDLE_DATA;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    bit_sync_cfg_if cfg_bus ();

    assign cfg_bus.presync_integral_gain      = bit_sync_config[PRESYNC_KI_MSB:PRESYNC_KI_LSB];
    assign cfg_bus.presync_proportional_gain  = bit_sync_config[PRESYNC_KP_MSB:PRESYNC_KP_LSB];
    assign cfg_bus.postsync_integral_gain     = bit_sync_config[POSTSYNC_KI_BIT];
    assign cfg_bus.postsync_proportional_gain = bit_sync_config[POSTSYNC_KP_BIT];
    assign cfg_bus.rate_offset_limit          = bit_sync_config[LIMIT_MSB:LIMIT_LSB];
    assign cfg_bus.sync_found                 = sync_found_i;

    bit_sync_gain_decode u_decode (
        .cfg (cfg_bus.decode)
    );

    wire logic next_frozen;
    wire logic next_track_en;

    // frozen while gated and no carrier
    assign next_frozen   = loop_freeze_until_carrier_i & ~carrier_sense_i;
    assign next_track_en = (cfg_bus.limit_steps != STEPS_NONE) & ~next_frozen;

    // ****************************************
    // Outputs to clock recovery
    // ****************************************
    // Registered so the loop sees a glitch-free value one cycle later
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            integral_gain_half_o <= KI_HALF_BASE;
            proportional_gain_o  <= KP_BASE;
            rate_limit_steps_o   <= STEPS_NONE;
            integral_track_en_o  <= 1'b0;
            loops_frozen_o       <= 1'b0;
        end else begin
            integral_gain_half_o <= cfg_bus.ki_half;
            proportional_gain_o  <= cfg_bus.kp;
            rate_limit_steps_o   <= cfg_bus.limit_steps;
            integral_track_en_o  <= next_track_en;
            loops_frozen_o       <= next_frozen;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_write_to_cfg;
        write_hit ##1 (bit_sync_config == $past(reg_wdata_i));
    endsequence

    property p_write_then_read;
        write_hit ##1 (read_hit && !write_hit) |=>
            (reg_rdata_o == $past(reg_wdata_i, 2));
    endproperty
    a_write_then_read: assert property (p_write_then_read)
        else $error("readback differs from value written");

    property p_write_stores;
        write_hit |-> s_write_to_cfg;
    endproperty
    a_write_stores: assert property (p_write_stores)
        else $error("write did not update register");

    property p_no_side_effect;
        !write_hit |=> $stable(bit_sync_config);
    endproperty
    a_no_side_effect: assert property (p_no_side_effect)
        else $error("register changed without a write");

    property p_presync_ki;
        !sync_found_i |=> integral_gain_half_o ==
            {($past(bit_sync_config[PRESYNC_KI_MSB:PRESYNC_KI_LSB]) + 2'h0 == 2'h3)
             ? 3'h4 : {1'b0, $past(bit_sync_config[PRESYNC_KI_MSB:PRESYNC_KI_LSB])} + 3'h1,
             1'b0};
    endproperty
    a_presync_ki: assert property (p_presync_ki)
        else $error("presync integral gain wrong");

    property p_presync_kp;
        !sync_found_i |=> proportional_gain_o ==
            {1'b0, $past(bit_sync_config[PRESYNC_KP_MSB:PRESYNC_KP_LSB])} + 3'h1;
    endproperty
    a_presync_kp: assert property (p_presync_kp)
        else $error("presync proportional gain wrong");

    property p_postsync_ki_half;
        sync_found_i && bit_sync_config[POSTSYNC_KI_BIT] |=>
            integral_gain_half_o == KI_HALF_BASE;
    endproperty
    a_postsync_ki_half: assert property (p_postsync_ki_half)
        else $error("postsync integral gain not half base");

    // Keeping presync must give the presync multiple itself, not just any non-half value
    property p_postsync_ki_keep;
        sync_found_i && !bit_sync_config[POSTSYNC_KI_BIT] |=>
            integral_gain_half_o ==
            {{1'b0, $past(bit_sync_config[PRESYNC_KI_MSB:PRESYNC_KI_LSB])} + 3'h1, 1'b0};
    endproperty
    a_postsync_ki_keep: assert property (p_postsync_ki_keep)
        else $error("postsync integral gain did not keep presync");

    property p_postsync_kp;
        sync_found_i && bit_sync_config[POSTSYNC_KP_BIT] |=>
            proportional_gain_o == KP_BASE;
    endproperty
    a_postsync_kp: assert property (p_postsync_kp)
        else $error("postsync proportional gain not base");

    property p_postsync_kp_keep;
        sync_found_i && !bit_sync_config[POSTSYNC_KP_BIT] |=>
            proportional_gain_o ==
            {1'b0, $past(bit_sync_config[PRESYNC_KP_MSB:PRESYNC_KP_LSB])} + 3'h1;
    endproperty
    a_postsync_kp_keep: assert property (p_postsync_kp_keep)
        else $error("postsync proportional gain did not keep presync");

    property p_limit_map;
        1'b1 |=> rate_limit_steps_o ==
            (($past(bit_sync_config[LIMIT_MSB:LIMIT_LSB]) == LIMIT_12P5) ? STEPS_12P5
             : {1'b0, $past(bit_sync_config[LIMIT_MSB:LIMIT_LSB])});
    endproperty
    a_limit_map: assert property (p_limit_map)
        else $error("rate offset limit decoded wrong");

    property p_track_off;
        (bit_sync_config[LIMIT_MSB:LIMIT_LSB] == LIMIT_OFF) |=> !integral_track_en_o;
    endproperty
    a_track_off: assert property (p_track_off)
        else $error("integral tracking enabled with limit off");

    sequence s_gated_dark;
        loop_freeze_until_carrier_i && !carrier_sense_i;
    endsequence

    property p_frozen;
        s_gated_dark |=> loops_frozen_o && !integral_track_en_o;
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("loops not frozen before carrier sense");

    property p_release;
        carrier_sense_i |=> !loops_frozen_o;
    endproperty
    a_release: assert property (p_release)
        else $error("loops still frozen after carrier sense");

    // Read data stands one cycle only, so a stale value is never mistaken for a read
    property p_rdata_idle;
        !read_hit |=> reg_rdata_o == READ_IDLE_DATA;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle outside a read");

endmodule : bit_sync_loop_config

`default_nettype wire

// file: src/bit_sync_pkg.sv
`default_nettype none

package bit_sync_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [5:0] BIT_SYNC_CONFIG_ADDR  = 6'h1a;
    localparam logic [7:0] BIT_SYNC_CONFIG_RESET = 8'h6c;
    localparam logic [7:0] READ_IDLE_DATA        = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PRESYNC_KI_MSB  = 7;
    localparam int PRESYNC_KI_LSB  = 6;
    localparam int PRESYNC_KP_MSB  = 5;
    localparam int PRESYNC_KP_LSB  = 4;
    localparam int POSTSYNC_KI_BIT = 3;
    localparam int POSTSYNC_KP_BIT = 2;
    localparam int LIMIT_MSB       = 1;
    localparam int LIMIT_LSB       = 0;

    // ****************************************
    // Decoded values
    // ****************************************
    // Integral gain counted in halves of the base gain
    localparam logic [3:0] KI_HALF_BASE = 4'h1;
    localparam logic [2:0] KP_BASE      = 3'h1;

    // Rate offset limit counted in steps of 3.125 %
    localparam logic [1:0] LIMIT_OFF     = 2'h0;
    localparam logic [1:0] LIMIT_3P125   = 2'h1;
    localparam logic [1:0] LIMIT_6P25    = 2'h2;
    localparam logic [1:0] LIMIT_12P5    = 2'h3;
    localparam logic [2:0] STEPS_NONE    = 3'h0;
    localparam logic [2:0] STEPS_3P125   = 3'h1;
    localparam logic [2:0] STEPS_6P25    = 3'h2;
    localparam logic [2:0] STEPS_12P5    = 3'h4;

endpackage : bit_sync_pkg

`default_nettype wire

// file: tb/bit_sync_loop_config_test.sv
`timescale 1ns/1ns
`default_nettype none

module bit_sync_loop_config_test
    import bit_sync_pkg::*;
;
    logic       clk_i;
    logic       reset_i;
    logic       sync_found_i;
    logic       carrier_sense_i;
    logic       gate_i;
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] ki_o;
    logic [2:0] kp_o;
    logic [2:0] steps_o;
    logic       track_o;
    logic       frozen_o;
    int         error_cnt;
    int         comparisons;

    bit_sync_loop_config dut (.clk_i(clk_i), .reset_i(reset_i), .reg_write_i(wr),
        .reg_read_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .sync_found_i(sync_found_i), .carrier_sense_i(carrier_sense_i),
        .loop_freeze_until_carrier_i(gate_i), .reg_rdata_o(rdata),
        .integral_gain_half_o(ki_o), .proportional_gain_o(kp_o),
        .rate_limit_steps_o(steps_o), .integral_track_en_o(track_o),
        .loops_frozen_o(frozen_o));

    host_port_model host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_write_o(wr),
        .reg_read_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic check_outputs(input logic [7:0] cfg);
        logic [3:0] ki;
        logic [2:0] kp;
        logic       frz;
        ki  = {1'b0, cfg[7:6], 1'b0} + 4'h2;
        kp  = {1'b0, cfg[5:4]} + 3'h1;
        frz = gate_i & ~carrier_sense_i;
        if (sync_found_i && cfg[3]) ki = 4'h1;
        if (sync_found_i && cfg[2]) kp = 3'h1;
        check("ki", {4'h0, ki_o}, {4'h0, ki});
        check("kp", {5'h00, kp_o}, {5'h00, kp});
        check("steps", {5'h00, steps_o}, (cfg[1:0] == 2'h3) ? 8'h04 : {6'h00, cfg[1:0]});
        check("track", {7'h00, track_o}, {7'h00, (cfg[1:0] != 2'h0) & ~frz});
        check("frozen", {7'h00, frozen_o}, {7'h00, frz});
    endtask : check_outputs

    task automatic read_check(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        check("rdata", d, exp);
    endtask : read_check

    // ****************************************
    // Scenarios
    // ****************************************
    // reset value
    task automatic test_reset;
        @(negedge clk_i);
        check_outputs(BIT_SYNC_CONFIG_RESET);
        read_check(BIT_SYNC_CONFIG_ADDR, 8'h6c);
        @(negedge clk_i);
        check("rdata idle", rdata, READ_IDLE_DATA);
    endtask : test_reset

    task automatic test_gain_table;
        logic [7:0] cfg;
        for (int s = 0; s < 2; s++) begin
            @(negedge clk_i);
            sync_found_i = s[0];
            for (int i = 0; i < 16; i++) begin
                cfg = {i[3:0], i[3:0]};
                host.write_reg(BIT_SYNC_CONFIG_ADDR, cfg);
                @(negedge clk_i);
                check_outputs(cfg);
                read_check(BIT_SYNC_CONFIG_ADDR, cfg);
            end
        end
        sync_found_i = 1'b0;
    endtask : test_gain_table

    task automatic test_freeze;
        host.write_reg(BIT_SYNC_CONFIG_ADDR, 8'h6d);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_i);
            gate_i          = ~i[0];
            carrier_sense_i = i[1];
            @(negedge clk_i);
            check_outputs(8'h6d);
        end
    endtask : test_freeze

    task automatic test_unmapped;
        host.write_reg(6'h1b, 8'h00);
        read_check(6'h1b, READ_IDLE_DATA);
        read_check(BIT_SYNC_CONFIG_ADDR, 8'h6d);
        @(negedge clk_i);
        reset_i = 1'b1;
        @(negedge clk_i);
        check("ki reset", {4'h0, ki_o}, 8'h01);
        check("kp reset", {5'h00, kp_o}, 8'h01);
        check("steps reset", {5'h00, steps_o}, 8'h00);
        check("flags reset", {6'h00, track_o, frozen_o}, 8'h00);
        check("rdata reset", rdata, READ_IDLE_DATA);
        reset_i = 1'b0;
        read_check(BIT_SYNC_CONFIG_ADDR, 8'h6c);
        check_outputs(BIT_SYNC_CONFIG_RESET);
    endtask : test_unmapped

    // write then read back to back
    task automatic test_back_to_back;
        logic [7:0] d;
        host.write_read(BIT_SYNC_CONFIG_ADDR, 8'h9e, d);
        check("rdata b2b", d, 8'h9e);
        @(negedge clk_i);
        check_outputs(8'h9e);
    endtask : test_back_to_back

    task automatic finish_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // ****************************************
    // Run
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Whole run is about two hundred cycles
    initial begin
        repeat (3000) @(posedge clk_i);
        error_cnt++;
        finish_test;
    end

    initial begin
        error_cnt       = 0;
        comparisons     = 0;
        reset_i         = 1'b1;
        sync_found_i    = 1'b0;
        carrier_sense_i = 1'b0;
        gate_i          = 1'b0;
        repeat (20) @(negedge clk_i);
        reset_i = 1'b0;
        test_reset;
        test_gain_table;
        test_freeze;
        test_unmapped;
        test_back_to_back;
        finish_test;
    end
endmodule : bit_sync_loop_config_test

`default_nettype wire

// file: tb/host_port_model.sv
`timescale 1ns/1ns
`default_nettype none

module host_port_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_write_o,
    output logic            reg_read_o,
    output logic      [5:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o
);
    initial begin
        reg_write_o = 1'b0;
        reg_read_o  = 1'b0;
        reg_addr_o  = 6'h00;
        reg_wdata_o = 8'h00;
    end

    // Idle lines show the inverse, so a stale address is never reused
    task automatic write_reg(input logic [5:0] addr, input logic [7:0] data);
        @(negedge clk_i);
        reg_write_o = 1'b1;
        reg_addr_o  = addr;
        reg_wdata_o = data;
        @(negedge clk_i);
        reg_write_o = 1'b0;
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
    endtask : write_reg

    task automatic read_reg(input logic [5:0] addr, output logic [7:0] data);
        @(negedge clk_i);
        reg_read_o = 1'b1;
        reg_addr_o = addr;
        @(negedge clk_i);
        data       = reg_rdata_i;
        reg_read_o = 1'b0;
        reg_addr_o = ~addr;
    endtask : read_reg

    // Write then read on the very next edge, as the port allows
    task automatic write_read(input logic [5:0] addr, input logic [7:0] wdat,
                              output logic [7:0] rdat);
        @(negedge clk_i);
        reg_write_o = 1'b1;
        reg_addr_o  = addr;
        reg_wdata_o = wdat;
        @(negedge clk_i);
        reg_write_o = 1'b0;
        reg_read_o  = 1'b1;
        reg_wdata_o = ~wdat;
        @(negedge clk_i);
        rdat        = reg_rdata_i;
        reg_read_o  = 1'b0;
        reg_addr_o  = ~addr;
    endtask : write_read
endmodule : host_port_model

`default_nettype wire
